// ---- core/uescr_consts.svh ----
// register offsets, field positions and reset values for the usb error/status/config slice
`ifndef UESCR_CONSTS_SVH
`define UESCR_CONSTS_SVH

`define UESCR_ADDR_W 4
`define UESCR_OFF_ERR_EN 4'h0
`define UESCR_OFF_STATUS 4'h4
`define UESCR_OFF_CONFIG 4'h8
`define UESCR_OFF_CTRL 4'hC

`define UESCR_RESP_OKAY 2'h0
`define UESCR_RESP_SLVERR 2'h2

`define UESCR_ERR_EN_RST 8'h00
`define UESCR_CFG_RST 8'h00
`define UESCR_CFG_MASK 8'h99
`define UESCR_ERR_EN_MASK 8'hFF
`define UESCR_CTRL_MASK 8'h07

`define UESCR_CFG_EYE 7
`define UESCR_CFG_SIDL 4
`define UESCR_CFG_LOW_SPEED_ONLY 3
`define UESCR_CFG_ASUSP 0

`define UESCR_CTRL_ERR_IE 0
`define UESCR_CTRL_SUSP 1
`define UESCR_CTRL_HOST 2
`define UESCR_CTRL_OVF 3

`define UESCR_STAT_EP_HI 7
`define UESCR_STAT_EP_LO 4
`define UESCR_STAT_DIR 3
`define UESCR_STAT_BANK 2

`endif

// ---- core/uescr_pkg.sv ----
// types for the usb error/status/config slice
package uescr_pkg;
  typedef enum logic [2:0] {
    UESCR_W_IDLE = 3'b001,
    UESCR_W_RESP = 3'b010,
    UESCR_W_RSV = 3'b100
  } uescr_wr_e;
endpackage : uescr_pkg

// ---- core/uescr_regs.sv ----
// usb error-enable, last-transfer status fifo and configuration registers over axi4-lite
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "uescr_consts.svh"
module uescr_regs
  import uescr_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] err_flags,
  input wire logic done_push,
  input wire logic [3:0] done_endpoint,
  input wire logic done_tx,
  input wire logic done_odd,
  input wire logic done_clear,
  input wire logic error_irq_master_enable,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  output logic transaction_done_flag,
  output logic usb_module_irq,
  output logic [7:0] err_irq_req,
  output logic eye_test_enable,
  output logic low_speed_only,
  output logic module_run,
  output logic module_suspend,
  output logic fifo_overflow
);

  localparam int PW = $clog2(FIFO_DEPTH);

  typedef struct packed {
    uescr_wr_e wst;
    logic [3:0] waddr;
    logic have_aw;
    logic have_w;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] err_en;
    logic [7:0] cfg;
    logic [2:0] ctrl;
    logic [PW-1:0] rd_ptr;
    logic [PW-1:0] wr_ptr;
    logic [PW:0] count;
    logic ovf;
    logic [7:0] irq_req;
    logic irq;
  } uescr_state_s;

  uescr_state_s st_ff;
  uescr_state_s nxt_st;
  logic [5:0] fifo_mem_ff [FIFO_DEPTH];
  logic [7:0] gated;
  logic head_pop;
  logic do_push;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] uescr_merge(input logic [7:0] old, input logic [31:0] d,
                                             input logic [3:0] be, input logic [7:0] msk);
    uescr_merge = be[0] ? (d[7:0] & msk) : old;
  endfunction : uescr_merge

  // one-hot select: bit 0 error enable, 1 status, 2 config, 3 control;
  // shared by both channels so a write and a read never disagree on the map
  function automatic logic [3:0] uescr_decode(input logic [3:0] a);
    case (a)
      `UESCR_OFF_ERR_EN: uescr_decode = 4'h1;
      `UESCR_OFF_STATUS: uescr_decode = 4'h2;
      `UESCR_OFF_CONFIG: uescr_decode = 4'h4;
      `UESCR_OFF_CTRL: uescr_decode = 4'h8;
      default: uescr_decode = 4'h0;
    endcase
  endfunction : uescr_decode

  // status byte from a fifo entry {endpoint, tx, odd}; bits 1..0 unimplemented
  function automatic logic [7:0] uescr_stat_word(input logic [5:0] ent);
    uescr_stat_word = {ent[5:2], ent[1], ent[0], 2'b00};
  endfunction : uescr_stat_word

  // ----------------------------------------------------------------
  // error gating
  // ----------------------------------------------------------------
  // one enable per flag; bit 1 flag source is already muxed by the host/device selection
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_gate
      assign gated[gi] = err_flags[gi] & st_ff.err_en[gi];
    end
  endgenerate

  assign head_pop = done_clear && (st_ff.count != '0);
  assign do_push = done_push && ((st_ff.count != (PW+1)'(FIFO_DEPTH)) || head_pop);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic wr_go;
    logic rd_go;
    logic [3:0] wsel;
    logic [3:0] rsel;
    logic [7:0] ctrl_w;
    wr_go = 1'b0;
    rd_go = 1'b0;
    wsel = uescr_decode(st_ff.waddr);
    rsel = uescr_decode(s_axi_araddr);
    ctrl_w = uescr_merge({5'h00, st_ff.ctrl}, st_ff.wdata, st_ff.wstrb, `UESCR_CTRL_MASK);
    nxt_st = st_ff;
    // write channel: take address and data in either order
    if (s_axi_awvalid && !st_ff.have_aw && st_ff.wst == UESCR_W_IDLE) begin
      nxt_st.have_aw = 1'b1;
      nxt_st.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_ff.have_w && st_ff.wst == UESCR_W_IDLE) begin
      nxt_st.have_w = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    case (st_ff.wst)
      UESCR_W_IDLE: begin
        wr_go = st_ff.have_aw && st_ff.have_w;
      end
      UESCR_W_RESP: begin
        if (s_axi_bready) begin
          nxt_st.wst = UESCR_W_IDLE;
        end
      end
      default: begin
        nxt_st.wst = UESCR_W_IDLE;
      end
    endcase
    if (wr_go) begin
      nxt_st.have_aw = 1'b0;
      nxt_st.have_w = 1'b0;
      nxt_st.wst = UESCR_W_RESP;
      // status is read-only: a write there is accepted and dropped
      nxt_st.bresp = (wsel == 4'h0) ? `UESCR_RESP_SLVERR : `UESCR_RESP_OKAY;
      if (wsel[0]) begin
        nxt_st.err_en = uescr_merge(st_ff.err_en, st_ff.wdata, st_ff.wstrb,
                                    `UESCR_ERR_EN_MASK);
      end
      if (wsel[2]) begin
        nxt_st.cfg = uescr_merge(st_ff.cfg, st_ff.wdata, st_ff.wstrb,
                                 `UESCR_CFG_MASK);
      end
      if (wsel[3]) begin
        nxt_st.ctrl = ctrl_w[2:0];
      end
    end
    // read channel: one outstanding read
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    rd_go = s_axi_arvalid && !st_ff.rvalid;
    if (rd_go) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = (rsel == 4'h0) ? `UESCR_RESP_SLVERR : `UESCR_RESP_OKAY;
      nxt_st.rdata = 32'h0000_0000;
      if (rsel[0]) begin
        nxt_st.rdata[7:0] = st_ff.err_en;
      end
      // head of fifo; reads while empty show stale data, software must check the done flag
      if (rsel[1]) begin
        nxt_st.rdata[7:0] = uescr_stat_word(fifo_mem_ff[st_ff.rd_ptr]);
      end
      if (rsel[2]) begin
        nxt_st.rdata[7:0] = st_ff.cfg;
      end
      // reading the control word clears the sticky overflow; a new overflow wins below
      if (rsel[3]) begin
        nxt_st.rdata[7:0] = {4'h0, st_ff.ovf, st_ff.ctrl};
        nxt_st.ovf = 1'b0;
      end
    end
    // status fifo
    if (head_pop) begin
      nxt_st.rd_ptr = PW'(st_ff.rd_ptr + 1'b1);
    end
    if (do_push) begin
      nxt_st.wr_ptr = PW'(st_ff.wr_ptr + 1'b1);
    end
    nxt_st.count = (PW+1)'(st_ff.count + (do_push ? 1 : 0) - (head_pop ? 1 : 0));
    if (done_push && !do_push) begin
      nxt_st.ovf = 1'b1;
    end
    // interrupt path registered so the output comes from flops
    nxt_st.irq_req = gated;
    nxt_st.irq = (|gated) & error_irq_master_enable;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.wst <= UESCR_W_IDLE;
      st_ff.err_en <= `UESCR_ERR_EN_RST;
      st_ff.cfg <= `UESCR_CFG_RST;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // entry holds endpoint, direction and bank; no reset needed for data
  always_ff @(posedge clk) begin
    if (ce && do_push) begin
      fifo_mem_ff[st_ff.wr_ptr] <= {done_endpoint, done_tx, done_odd};
    end
  end

  // ----------------------------------------------------------------
  // bus outputs
  // ----------------------------------------------------------------
  // no request is taken while frozen, else the master would see it accepted and lost;
  // a response already offered stays offered, so ce should not drop mid-transfer
  assign s_axi_awready = ce && (st_ff.wst == UESCR_W_IDLE) && !st_ff.have_aw;
  assign s_axi_wready = ce && (st_ff.wst == UESCR_W_IDLE) && !st_ff.have_w;
  assign s_axi_bvalid = (st_ff.wst == UESCR_W_RESP);
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = ce && !st_ff.rvalid;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;

  // ----------------------------------------------------------------
  // status and interrupt outputs
  // ----------------------------------------------------------------
  assign transaction_done_flag = (st_ff.count != '0);
  assign err_irq_req = st_ff.irq_req;
  assign usb_module_irq = st_ff.irq;
  assign fifo_overflow = st_ff.ovf;

  // ----------------------------------------------------------------
  // mode and power outputs
  // ----------------------------------------------------------------
  assign eye_test_enable = st_ff.cfg[`UESCR_CFG_EYE];
  assign low_speed_only = st_ff.cfg[`UESCR_CFG_LOW_SPEED_ONLY];
  assign module_run = !(st_ff.cfg[`UESCR_CFG_SIDL] && cpu_idle) && !module_suspend;
  assign module_suspend = st_ff.ctrl[`UESCR_CTRL_SUSP] ||
                          (st_ff.cfg[`UESCR_CFG_ASUSP] && cpu_sleep);

endmodule : uescr_regs

// ---- tb/uescr_chk.sv ----
// concurrent checks on the usb error/status/config slice ports
`timescale 1ns/1ps
module uescr_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] err_flags,
  input wire logic error_irq_master_enable,
  input wire logic done_push,
  input wire logic done_clear,
  input wire logic cpu_idle,
  input wire logic transaction_done_flag,
  input wire logic usb_module_irq,
  input wire logic [7:0] err_irq_req,
  input wire logic module_suspend,
  input wire logic module_run
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  irq_gate_a: assert property ($past(ce) |-> usb_module_irq ==
    (|err_irq_req && $past(error_irq_master_enable))) else $error("irq mismatch");
  req_flag_a: assert property ((err_irq_req & ~$past(err_flags)) == 8'h00)
    else $error("request without flag");
  done_rise_a: assert property ($rose(transaction_done_flag) |-> $past(done_push))
    else $error("done set without push");
  // a reset also drops the flag, so that edge is skipped
  done_fall_a: assert property (!$past(rst) && $fell(transaction_done_flag) |->
    $past(done_clear)) else $error("done cleared without pop");
  idle_run_a: assert property (!cpu_idle && !module_suspend |-> module_run)
    else $error("stopped outside idle");
  susp_stop_a: assert property (module_suspend |-> !module_run)
    else $error("running while suspended");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data unstable");
  rdata_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper bits set");
  read_lat_a: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
    else $error("read answer late");
endmodule : uescr_chk
bind uescr_regs uescr_chk uescr_chk_inst (.*);

// ---- tb/uescr_far.sv ----
// far-side usb link model: error flags and completed-transfer records
`timescale 1ns/1ps
module uescr_far (
  input wire logic clk,
  output logic [7:0] err_flags,
  output logic done_push,
  output logic [3:0] done_endpoint,
  output logic done_tx,
  output logic done_odd
);
  initial begin
    err_flags = 8'h00;
    done_push = 1'h0;
    {done_endpoint, done_tx, done_odd} = 6'h00;
  end
  task automatic set_err(input logic [7:0] f);
    err_flags <= f;
  endtask : set_err
  // one-cycle record; lines scrambled once released so stale values cannot pass
  task automatic push(input logic [5:0] r);
    @(posedge clk);
    done_push <= 1'h1;
    {done_endpoint, done_tx, done_odd} <= r;
    @(posedge clk);
    done_push <= 1'h0;
    {done_endpoint, done_tx, done_odd} <= ~r;
  endtask : push
endmodule : uescr_far

// ---- tb/uescr_regs_tb.sv ----
// self-checking bench for the usb error/status/config register slice
`timescale 1ns/1ps
`include "uescr_consts.svh"
module uescr_regs_tb;
  logic clk = 1'h0, rst = 1'h1, ce = 1'h1, done_clear = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v, e;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic error_irq_master_enable = 1'h0, cpu_idle = 1'h0, cpu_sleep = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] err_flags, err_irq_req;
  logic [3:0] done_endpoint;
  logic done_push, done_tx, done_odd, transaction_done_flag, usb_module_irq;
  logic eye_test_enable, low_speed_only, module_run, module_suspend, fifo_overflow;
  logic [5:0] q[$];
  logic [1:0] rsp;
  int fails = 0, checked = 0, seed = 38205;
  uescr_regs uescr_regs_inst (.*);
  uescr_far uescr_far_inst (.*);
  always #12.5 clk = ~clk;
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      fails++;
      $display("wrong value %s expected %h seen %h", s, x, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rc(input logic [3:0] a, input logic [31:0] x, input string s);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    chk(s, s_axi_rdata, x);
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rc
  function automatic logic [31:0] cfg_exp(input logic [31:0] w);
    return {24'h0, w[7:0] & `UESCR_CFG_MASK};
  endfunction : cfg_exp
  function automatic logic [31:0] stat_exp(input logic [5:0] r);
    return {24'h0, r, 2'h0};
  endfunction : stat_exp
  task automatic print_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    rc(`UESCR_OFF_ERR_EN, 32'h0, "err_en");
    rc(`UESCR_OFF_CONFIG, 32'h0, "cfg");
    repeat (6) begin
      v = $random(seed);
      wr(`UESCR_OFF_CONFIG, v);
      rc(`UESCR_OFF_CONFIG, cfg_exp(v), "cfg");
      chk("eye", eye_test_enable, v[7]);
      chk("lsd", low_speed_only, v[3]);
    end
    wr(`UESCR_OFF_CONFIG, 32'h11);
    {cpu_idle, cpu_sleep} <= 2'h3;
    #1;
    chk("run", module_run, 1'h0);
    chk("susp", module_suspend, 1'h1);
    wr(`UESCR_OFF_CONFIG, 32'h0);
    chk("run", module_run, 1'h1);
    chk("susp", module_suspend, 1'h0);
    wr(`UESCR_OFF_CTRL, 32'h2);
    chk("susp", module_suspend, 1'h1);
    wr(`UESCR_OFF_CTRL, 32'h0);
    {cpu_idle, cpu_sleep} <= 2'h0;
    $display("config test done");
    error_irq_master_enable <= 1'h1;
    repeat (8) begin
      v = $random(seed);
      e = $random(seed);
      wr(`UESCR_OFF_ERR_EN, v);
      rc(`UESCR_OFF_ERR_EN, {24'h0, v[7:0]}, "err_en");
      uescr_far_inst.set_err(e[7:0]);
      repeat (3) @(posedge clk);
      chk("req", err_irq_req, v[7:0] & e[7:0]);
      chk("irq", usb_module_irq, |(v[7:0] & e[7:0]));
    end
    wr(`UESCR_OFF_ERR_EN, 32'hFF);
    error_irq_master_enable <= 1'h0;
    uescr_far_inst.set_err(8'h02);
    repeat (3) @(posedge clk);
    chk("req", err_irq_req, 8'h02);
    chk("irq", usb_module_irq, 1'h0);
    $display("error enable test done");
    // five pushes into four places: the last is dropped
    repeat (5) begin
      v = $random(seed);
      q.push_back(v[5:0]);
      uescr_far_inst.push(v[5:0]);
    end
    #1;
    chk("ovf", fifo_overflow, 1'h1);
    chk("done", transaction_done_flag, 1'h1);
    for (int i = 0; i < 4; i++) begin
      rc(`UESCR_OFF_STATUS, stat_exp(q[i]), "stat");
      done_clear <= 1'h1;
      @(posedge clk);
      done_clear <= 1'h0;
    end
    repeat (2) @(posedge clk);
    chk("done", transaction_done_flag, 1'h0);
    $display("status fifo test done");
    rc(`UESCR_OFF_CTRL, 32'h8, "ctrl");
    chk("ovf", fifo_overflow, 1'h0);
    chk("rresp", rsp, `UESCR_RESP_OKAY);
    wr(4'h2, 32'hFF);
    chk("bresp", rsp, `UESCR_RESP_SLVERR);
    rc(4'h2, 32'h0, "unmapped");
    chk("rresp", rsp, `UESCR_RESP_SLVERR);
    wr(`UESCR_OFF_STATUS, 32'hFF);
    chk("bresp", rsp, `UESCR_RESP_OKAY);
    $display("response test done");
    uescr_far_inst.push(6'h2D);
    rc(`UESCR_OFF_STATUS, stat_exp(6'h2D), "stat");
    wr(`UESCR_OFF_CONFIG, 32'hFF);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rc(`UESCR_OFF_CONFIG, 32'h0, "cfg");
    rc(`UESCR_OFF_ERR_EN, 32'h0, "err_en");
    chk("done", transaction_done_flag, 1'h0);
    chk("req", err_irq_req, 8'h00);
    $display("reset test done");
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict();
  end
endmodule : uescr_regs_tb
